// file: rtl/mct_pkg.sv
/*
 * Constants for the module management and control block: serial bus
 * address, byte map, field codes and timing figures.
 * Assumes a 100 MHz system clock; all cycle counts are derived from it.
 */
package mct_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_KHZ = 100000;
  // Serial bus device address, 8-bit form with the direction bit clear
  localparam logic [7:0] DEV_ADDR = 8'hA0;
  // Byte map
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_FLAGS = 8'h03;
  localparam logic [7:0] ADDR_POWER = 8'h5D;
  localparam logic [7:0] ADDR_MASK = 8'h64;
  localparam logic [7:0] ADDR_LOOPBACK = 8'h69;
  localparam logic [7:0] ADDR_RATE = 8'h6A;
  // Field positions
  localparam int STATUS_NOT_READY_BIT = 0;
  localparam int POWER_DOWN_BIT = 0;
  localparam int FLAG_READY_BIT = 3;
  localparam int NUM_COND = 3;
  // Codes and reset values
  localparam logic [7:0] RATE_100G = 8'h00;
  localparam logic [7:0] RATE_40G = 8'h0B;
  localparam logic [7:0] LOOP_NONE = 8'h00;
  localparam logic [7:0] LOOP_ELEC = 8'h01;
  localparam logic [7:0] LOOP_OPT = 8'h02;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [1:0] LB_OFF = 2'h0;
  localparam logic [1:0] LB_ELEC = 2'h1;
  localparam logic [1:0] LB_OPT = 2'h2;
  // Timing
  localparam int T_INIT_MS = 2000;
  localparam int T_INIT_CYC = T_INIT_MS * CLK_KHZ;
  localparam int T_RST_MIN_NS = 2000;
  localparam logic [7:0] RST_FILT_CYC = 8'((T_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_DEV = 4'b0001,
    ST_DEV_ACK = 4'b0010,
    ST_PTR = 4'b0011,
    ST_PTR_ACK = 4'b0100,
    ST_WR = 4'b0101,
    ST_WR_ACK = 4'b0110,
    ST_RD = 4'b0111,
    ST_RD_ACK = 4'b1000
  } mct_state_t;
endpackage

// file: rtl/mct_top.sv
/*
 * Management and control block: serial bus slave, control bytes, flag
 * and mask logic, interrupt, low power and initialisation timing.
 * Assumes the host is the bus master and that all pins are asynchronous.
 */
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////
module mct_top #(
  parameter int INIT_WAIT_CYC = mct_pkg::T_INIT_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic module_select_n,
  input wire logic module_reset_in_n,
  input wire logic low_power_request,
  input wire logic [mct_pkg::NUM_COND-1:0] cond_in,
  output logic interrupt_out_n,
  output logic low_power_mode,
  output logic [1:0] loopback_mode,
  output logic rate_40g,
  output logic module_ready
);
  import mct_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for every input pin except rst_b
  localparam int NSYNC = 5 + NUM_COND;
  // Reset to each pin's idle level, so release shows no false condition or request
  localparam logic [NSYNC-1:0] SYNC_IDLE = {{NUM_COND{1'b0}}, 5'h0F};
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic scl_d_r;
  logic sda_d_r;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_r <= SYNC_IDLE;
      sync2_r <= SYNC_IDLE;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      sync1_r <= {cond_in, low_power_request, module_reset_in_n, module_select_n, sda_in, scl_in};
      sync2_r <= sync1_r;
      scl_d_r <= sync2_r[0];
      sda_d_r <= sync2_r[1];
    end
  end
  logic scl_s, sda_s, sel_s, mrst_s, lp_s;
  logic [NUM_COND-1:0] cond_s;
  assign scl_s = sync2_r[0];
  assign sda_s = sync2_r[1];
  assign sel_s = !sync2_r[2];
  assign mrst_s = sync2_r[3];
  assign lp_s = sync2_r[4];
  assign cond_s = sync2_r[NSYNC-1:5];
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign start_det = scl_s && scl_d_r && !sda_s && sda_d_r;
  assign stop_det = scl_s && scl_d_r && sda_s && !sda_d_r;

  //////////////////////////////////////////////////////////////////////////
  // Reset pin filter and initialisation timer
  logic [7:0] mrst_cnt_r;
  logic mrst_req;
  assign mrst_req = (mrst_cnt_r == RST_FILT_CYC);
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      mrst_cnt_r <= 8'h00;
    else if (mrst_s)
      mrst_cnt_r <= 8'h00;
    else if (!mrst_req)
      mrst_cnt_r <= mrst_cnt_r + 8'h01;
  end
  // Short glitches on the reset pin are ignored; only a held low resets
  logic [31:0] init_cnt_r;
  logic init_busy_r;
  logic init_done;
  assign init_done = init_busy_r && !mrst_req && (init_cnt_r >= 32'(INIT_WAIT_CYC - 1));
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      init_busy_r <= 1'b1;
      init_cnt_r <= 32'h0000_0000;
    end
    else if (mrst_req)
    begin
      init_busy_r <= 1'b1;
      init_cnt_r <= 32'h0000_0000;
    end
    else if (init_done)
      init_busy_r <= 1'b0;
    else if (init_busy_r)
      init_cnt_r <= init_cnt_r + 32'h0000_0001;
  end
  assign module_ready = !init_busy_r && !low_power_mode;

  //////////////////////////////////////////////////////////////////////////
  // Serial bus slave
  mct_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] sh_r;
  logic [7:0] ptr_r;
  logic [7:0] rd_sh_r;
  logic oe_r;
  logic [7:0] rd_byte;
  logic wr_stb;
  logic rd_load;
  logic [7:0] flags_r;
  logic [7:0] mask_r;
  logic [7:0] power_r;
  logic [7:0] loopback_select_r;
  logic [7:0] line_rate_select_r;
  logic [7:0] mask_sh_r;
  logic [7:0] power_sh_r;
  logic [7:0] rd_clr_r;
  logic byte_done;
  assign byte_done = (bit_cnt_r == BITS_PER_BYTE);
  assign wr_stb = scl_fall && state_r == ST_WR && byte_done;
  assign rd_load = scl_fall && ((state_r == ST_DEV_ACK && sh_r[0]) || state_r == ST_RD_ACK);
  // Byte to send next: the pointer moves on after each acknowledged read byte
  logic [7:0] rd_ptr;
  assign rd_ptr = (state_r == ST_RD_ACK) ? ptr_r + 8'h01 : ptr_r;

  always_comb
  begin
    rd_byte = BYTE_RESET;
    unique case (rd_ptr)
      ADDR_STATUS: rd_byte[STATUS_NOT_READY_BIT] = init_busy_r;
      ADDR_FLAGS: rd_byte = flags_r;
      ADDR_POWER: rd_byte = power_sh_r;
      ADDR_MASK: rd_byte = mask_sh_r;
      ADDR_LOOPBACK: rd_byte = loopback_select_r;
      ADDR_RATE: rd_byte = line_rate_select_r;
      default: rd_byte = BYTE_RESET;
    endcase
  end

  // Deselect drops any transfer at once, well inside the allowed time
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      sh_r <= BYTE_RESET;
      ptr_r <= BYTE_RESET;
      rd_sh_r <= BYTE_RESET;
      oe_r <= 1'b0;
    end
    else if (!sel_s || stop_det)
    begin
      state_r <= ST_IDLE;
      oe_r <= 1'b0;
    end
    else if (start_det)
    begin
      state_r <= ST_DEV;
      bit_cnt_r <= 4'h0;
      oe_r <= 1'b0;
    end
    else if (scl_rise)
    begin
      // The device's own acknowledge bits are not shifted in, so the direction bit stays in sh_r[0]
      if (state_r != ST_DEV_ACK && state_r != ST_PTR_ACK && state_r != ST_WR_ACK)
        sh_r <= {sh_r[6:0], sda_s};
      bit_cnt_r <= bit_cnt_r + 4'h1;
      if (state_r == ST_RD_ACK && sda_s)
        state_r <= ST_IDLE;
    end
    else if (scl_fall)
    begin
      unique case (state_r)
        ST_IDLE: oe_r <= 1'b0;
        ST_DEV:
          if (byte_done && sh_r[7:1] == DEV_ADDR[7:1])
          begin
            state_r <= ST_DEV_ACK;
            oe_r <= 1'b1;
          end
          else if (byte_done)
            state_r <= ST_IDLE;
        ST_DEV_ACK:
        begin
          bit_cnt_r <= 4'h0;
          state_r <= sh_r[0] ? ST_RD : ST_PTR;
          rd_sh_r <= rd_byte;
          oe_r <= sh_r[0] && !rd_byte[7];
        end
        ST_PTR, ST_WR:
          if (byte_done)
          begin
            state_r <= (state_r == ST_PTR) ? ST_PTR_ACK : ST_WR_ACK;
            oe_r <= 1'b1;
            if (state_r == ST_PTR)
              ptr_r <= sh_r;
          end
        ST_PTR_ACK, ST_WR_ACK:
        begin
          state_r <= ST_WR;
          bit_cnt_r <= 4'h0;
          oe_r <= 1'b0;
          if (state_r == ST_WR_ACK)
            ptr_r <= ptr_r + 8'h01;
        end
        ST_RD:
          if (byte_done)
          begin
            state_r <= ST_RD_ACK;
            oe_r <= 1'b0;
          end
          else
            oe_r <= !rd_sh_r[3'(7 - bit_cnt_r)];
        ST_RD_ACK:
        begin
          state_r <= ST_RD;
          bit_cnt_r <= 4'h0;
          ptr_r <= ptr_r + 8'h01;
          rd_sh_r <= rd_byte;
          oe_r <= !rd_byte[7];
        end
      endcase
    end
  end
  assign sda_oe = oe_r;
  assign sda_out = 1'b0;

  //////////////////////////////////////////////////////////////////////////
  // Control bytes; staged mask and power bytes take effect at stop
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      loopback_select_r <= BYTE_RESET;
      line_rate_select_r <= BYTE_RESET;
      mask_sh_r <= BYTE_RESET;
      power_sh_r <= BYTE_RESET;
      mask_r <= BYTE_RESET;
      power_r <= BYTE_RESET;
      rd_clr_r <= BYTE_RESET;
    end
    else if (mrst_req)
    begin
      loopback_select_r <= BYTE_RESET;
      line_rate_select_r <= BYTE_RESET;
      mask_sh_r <= BYTE_RESET;
      power_sh_r <= BYTE_RESET;
      mask_r <= BYTE_RESET;
      power_r <= BYTE_RESET;
      rd_clr_r <= BYTE_RESET;
    end
    else
    begin
      if (wr_stb && ptr_r == ADDR_LOOPBACK)
        loopback_select_r <= sh_r;
      if (wr_stb && ptr_r == ADDR_RATE)
        line_rate_select_r <= sh_r;
      if (wr_stb && ptr_r == ADDR_MASK)
        mask_sh_r <= sh_r;
      if (wr_stb && ptr_r == ADDR_POWER)
        power_sh_r <= sh_r;
      if (rd_load && rd_ptr == ADDR_FLAGS)
        rd_clr_r <= rd_clr_r | flags_r;
      if (stop_det)
      begin
        mask_r <= mask_sh_r;
        power_r <= power_sh_r;
        rd_clr_r <= BYTE_RESET;
      end
    end
  end

  // Selections follow only listed codes; anything else keeps the last one
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rate_40g <= 1'b0;
      loopback_mode <= LB_OFF;
    end
    else
    begin
      if (line_rate_select_r == RATE_40G)
        rate_40g <= 1'b1;
      else if (line_rate_select_r == RATE_100G)
        rate_40g <= 1'b0;
      if (loopback_select_r == LOOP_NONE)
        loopback_mode <= LB_OFF;
      else if (loopback_select_r == LOOP_ELEC)
        loopback_mode <= LB_ELEC;
      else if (loopback_select_r == LOOP_OPT)
        loopback_mode <= LB_OPT;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Flags, interrupt and power level
  // A condition present while its flag is being cleared keeps it set
  logic [7:0] flag_set;
  always_comb
  begin
    flag_set = BYTE_RESET;
    flag_set[NUM_COND-1:0] = cond_s;
    flag_set[FLAG_READY_BIT] = init_done;
  end
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      flags_r <= BYTE_RESET;
    else if (stop_det)
      flags_r <= (flags_r & ~rd_clr_r) | flag_set;
    else
      flags_r <= flags_r | flag_set;
  end
  logic irq_act;
  assign irq_act = |(flags_r & ~mask_r) || flags_r[FLAG_READY_BIT];
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      interrupt_out_n <= 1'b1;
      low_power_mode <= 1'b0;
    end
    else
    begin
      interrupt_out_n <= !irq_act;
      low_power_mode <= lp_s || power_r[POWER_DOWN_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  property p_rate_valid;
    @(posedge sys_clk) disable iff (!rst_b)
    $changed(rate_40g) |-> $past(line_rate_select_r) == RATE_40G
      || $past(line_rate_select_r) == RATE_100G;
  endproperty
  a_rate_valid: assert property (p_rate_valid) else $error("rate changed on bad code");
  property p_loop_valid;
    @(posedge sys_clk) disable iff (!rst_b)
    loopback_select_r == LOOP_OPT |=> loopback_mode == LB_OPT;
  endproperty
  a_loop_valid: assert property (p_loop_valid) else $error("optical loopback not set");
  property p_reset_filter;
    @(posedge sys_clk) disable iff (!rst_b)
    mrst_req |=> init_busy_r && init_cnt_r == 32'h0000_0000;
  endproperty
  a_reset_filter: assert property (p_reset_filter) else $error("reset pin not honoured");
  property p_init_bound;
    @(posedge sys_clk) disable iff (!rst_b)
    init_busy_r |-> init_cnt_r < 32'(INIT_WAIT_CYC);
  endproperty
  a_init_bound: assert property (p_init_bound) else $error("init overran");
  property p_ready_irq;
    @(posedge sys_clk) disable iff (!rst_b)
    $fell(init_busy_r) |-> flags_r[FLAG_READY_BIT] ##1 !interrupt_out_n;
  endproperty
  a_ready_irq: assert property (p_ready_irq) else $error("ready without interrupt");
  property p_lp_pin;
    @(posedge sys_clk) disable iff (!rst_b)
    lp_s |=> low_power_mode;
  endproperty
  a_lp_pin: assert property (p_lp_pin) else $error("low power not entered");
  property p_irq_set;
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(cond_s[0]) && !mask_r[0] |=> flags_r[0] ##1 !interrupt_out_n;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("loss flag missed");
  property p_irq_release;
    @(posedge sys_clk) disable iff (!rst_b)
    !irq_act |=> interrupt_out_n;
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("interrupt stuck");
  property p_deselect;
    @(posedge sys_clk) disable iff (!rst_b)
    !sel_s |=> state_r == ST_IDLE && !sda_oe;
  endproperty
  a_deselect: assert property (p_deselect) else $error("answered while deselected");
  property p_pdown;
    @(posedge sys_clk) disable iff (!rst_b)
    power_r[POWER_DOWN_BIT] |=> low_power_mode && !module_ready;
  endproperty
  a_pdown: assert property (p_pdown) else $error("power down ignored");
  c_write: cover property (@(posedge sys_clk) disable iff (!rst_b) wr_stb);
  c_read_flags: cover property (@(posedge sys_clk) disable iff (!rst_b)
    rd_load && rd_ptr == ADDR_FLAGS);
  c_ready: cover property (@(posedge sys_clk) disable iff (!rst_b) $fell(init_busy_r));
endmodule

// file: verification/mct_host_model.sv
/*
 * Host side of the two-wire management bus: bit, byte and register
 * transfer tasks called by the bench.
 * Assumes the bench resolves the open-drain data wire with a pull-up.
 */
`timescale 1ns/1ps
module mct_host_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  import mct_pkg::*;
  // Quarter of the 125 ns serial clock period
  localparam real Q = 31.25;
  //////////////////////////////////////////////////////////////////////////
  // Bus idles with both lines released; clock stands still between frames
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // Data changes a quarter period after the fall, well clear of the edge
  task automatic put_bit(input logic b);
    sda_low = !b;
    #Q;
    scl = 1'b1;
    #(2 * Q);
    scl = 1'b0;
    #Q;
  endtask
  task automatic get_bit(output logic b);
    sda_low = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    b = sda;
    #Q;
    scl = 1'b0;
    #Q;
  endtask
  task automatic h_start();
    sda_low = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sda_low = 1'b1;
    #Q;
    scl = 1'b0;
    #Q;
  endtask
  task automatic h_stop();
    sda_low = 1'b1;
    #Q;
    scl = 1'b1;
    #Q;
    sda_low = 1'b0;
    #(2 * Q);
  endtask
  task automatic tx_byte(input logic [7:0] d, output logic ack);
    logic nak;
    for (int i = 7; i >= 0; i--)
    begin
      put_bit(d[i]);
    end
    get_bit(nak);
    ack = !nak;
  endtask
  task automatic rx_byte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
    begin
      get_bit(d[i]);
    end
    put_bit(!ack);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic reg_write(input logic [7:0] ptr, input logic [7:0] d, output logic ack);
    logic a0, a1, a2;
    h_start();
    tx_byte(DEV_ADDR, a0);
    tx_byte(ptr, a1);
    tx_byte(d, a2);
    h_stop();
    ack = a0 & a1 & a2;
  endtask
  // Single-byte read ends with a NACK so the device lets go of the wire
  task automatic reg_read(input logic [7:0] ptr, output logic [7:0] d);
    logic a;
    h_start();
    tx_byte(DEV_ADDR, a);
    tx_byte(ptr, a);
    h_start();
    tx_byte(DEV_ADDR | 8'h01, a);
    rx_byte(1'b0, d);
    h_stop();
  endtask
  // Two-byte read: ACK after the first byte, NACK after the second
  task automatic reg_read2(input logic [7:0] ptr, output logic [7:0] d0, output logic [7:0] d1);
    logic a;
    h_start();
    tx_byte(DEV_ADDR, a);
    tx_byte(ptr, a);
    h_start();
    tx_byte(DEV_ADDR | 8'h01, a);
    rx_byte(1'b1, d0);
    rx_byte(1'b0, d1);
    h_stop();
  endtask
endmodule

// file: verification/mct_top_tb_top.sv
/*
 * Self-checking bench for the management and control block.
 * Assumes the host model drives the serial lines and the bench the pins.
 */
`timescale 1ns/1ps
module mct_top_tb_top;
  import mct_pkg::*;
  localparam int INIT_CYC = 50;
  logic sys_clk, rst_b, scl, host_low, sda_out, sda_oe, sda_wire;
  logic module_select_n, module_reset_in_n, low_power_request;
  logic [NUM_COND-1:0] cond_in;
  logic interrupt_out_n, low_power_mode, rate_40g, module_ready;
  logic [1:0] loopback_mode;
  int errors = 0;
  int n_tests = 0;
  // Wired-AND of both parties, pulled up when released
  assign sda_wire = !(host_low || (sda_oe && !sda_out));
  mct_top #(.INIT_WAIT_CYC(INIT_CYC)) mct_top_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .module_select_n(module_select_n),
    .module_reset_in_n(module_reset_in_n), .low_power_request(low_power_request),
    .cond_in(cond_in), .interrupt_out_n(interrupt_out_n),
    .low_power_mode(low_power_mode), .loopback_mode(loopback_mode),
    .rate_40g(rate_40g), .module_ready(module_ready));
  mct_host_model mct_host_model_i (.scl(scl), .sda_low(host_low), .sda(sda_wire));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  function automatic logic pick(input int sel);
    case (sel)
      0: return interrupt_out_n;
      1: return low_power_mode;
      default: return module_ready;
    endcase
  endfunction
  // Bounded poll, then a compare, so a hang shows as one mismatch
  task automatic wait_on(input int sel, input logic exp, input int maxc);
    int k;
    k = 0;
    while (pick(sel) !== exp && k < maxc)
    begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    chk({7'h00, pick(sel)}, {7'h00, exp});
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic ack;
    mct_host_model_i.reg_write(ptr, d, ack);
    chk({7'h00, ack}, 8'h01);
  endtask
  task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
    logic [7:0] d;
    mct_host_model_i.reg_read(ptr, d);
    chk(d, exp);
  endtask
  task automatic rd2_chk(input logic [7:0] ptr, input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] d0, d1;
    mct_host_model_i.reg_read2(ptr, d0, d1);
    chk(d0, e0);
    chk(d1, e1);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_init();
    chk({7'h00, module_ready}, 8'h00);
    wait_on(0, 1'b0, 200);
    chk({7'h00, module_ready}, 8'h01);
    rd_chk(ADDR_STATUS, 8'h00);
    rd_chk(ADDR_FLAGS, 8'h08);
    wait_on(0, 1'b1, 50000);
    rd_chk(ADDR_RATE, 8'h00);
    rd_chk(ADDR_LOOPBACK, 8'h00);
  endtask
  task automatic t_codes();
    logic [7:0] codes [4] = '{8'h01, 8'h02, 8'h03, 8'h00};
    logic [1:0] modes [4] = '{LB_ELEC, LB_OPT, LB_OPT, LB_OFF};
    wr(ADDR_RATE, RATE_40G);
    chk({7'h00, rate_40g}, 8'h01);
    wr(ADDR_RATE, 8'h05);
    chk({7'h00, rate_40g}, 8'h01);
    rd_chk(ADDR_RATE, 8'h05);
    wr(ADDR_RATE, RATE_100G);
    chk({7'h00, rate_40g}, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_LOOPBACK, codes[i]);
      chk({6'h00, loopback_mode}, {6'h00, modes[i]});
      rd_chk(ADDR_LOOPBACK, codes[i]);
    end
    wr(8'h70, 8'h5A);
    rd_chk(8'h70, 8'h00);
  endtask
  task automatic t_flags();
    for (int i = 0; i < NUM_COND; i++)
    begin
      tick();
      cond_in = 3'h1 << i;
      wait_on(0, 1'b0, 1000);
      tick();
      cond_in = 3'h0;
      rd_chk(ADDR_FLAGS, 8'h01 << i);
      wait_on(0, 1'b1, 50000);
    end
  endtask
  task automatic t_mask();
    wr(ADDR_MASK, 8'h02);
    rd_chk(ADDR_MASK, 8'h02);
    tick();
    cond_in = 3'h2;
    repeat (100) tick();
    chk({7'h00, interrupt_out_n}, 8'h01);
    wr(ADDR_MASK, 8'h00);
    wait_on(0, 1'b0, 1000);
    rd_chk(ADDR_FLAGS, 8'h02);
    tick();
    cond_in = 3'h0;
    rd_chk(ADDR_FLAGS, 8'h02);
    wait_on(0, 1'b1, 50000);
    rd_chk(ADDR_FLAGS, 8'h00);
  endtask
  task automatic t_power();
    tick();
    low_power_request = 1'b1;
    wait_on(1, 1'b1, 10000);
    chk({7'h00, module_ready}, 8'h00);
    tick();
    low_power_request = 1'b0;
    wait_on(2, 1'b1, 1000);
    wr(ADDR_POWER, 8'h01);
    wait_on(1, 1'b1, 10000);
    rd_chk(ADDR_POWER, 8'h01);
    wr(ADDR_POWER, 8'h00);
    wait_on(2, 1'b1, 30000);
  endtask
  task automatic t_select();
    logic ack;
    tick();
    module_select_n = 1'b1;
    repeat (10000) tick();
    mct_host_model_i.reg_write(ADDR_RATE, RATE_40G, ack);
    chk({7'h00, ack}, 8'h00);
    chk({7'h00, rate_40g}, 8'h00);
    tick();
    module_select_n = 1'b0;
    repeat (10000) tick();
    wr(ADDR_RATE, RATE_40G);
    chk({7'h00, rate_40g}, 8'h01);
    rd2_chk(ADDR_LOOPBACK, LOOP_NONE, RATE_40G);
  endtask
  // Bench holds the pin low for half the minimum width, then well past it for a real reset
  task automatic t_reset();
    tick();
    module_reset_in_n = 1'b0;
    repeat (100) tick();
    module_reset_in_n = 1'b1;
    repeat (10) tick();
    chk({7'h00, rate_40g}, 8'h01);
    module_reset_in_n = 1'b0;
    repeat (300) tick();
    module_reset_in_n = 1'b1;
    tick();
    chk({7'h00, module_ready}, 8'h00);
    wait_on(0, 1'b0, 200);
    chk({7'h00, module_ready}, 8'h01);
    rd_chk(ADDR_RATE, 8'h00);
    rd_chk(ADDR_FLAGS, 8'h08);
    wait_on(0, 1'b1, 50000);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    rst_b = 1'b0;
    module_select_n = 1'b0;
    module_reset_in_n = 1'b1;
    low_power_request = 1'b0;
    cond_in = 3'h0;
    repeat (16) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    tick();
    t_init();
    t_codes();
    t_flags();
    t_mask();
    t_power();
    t_select();
    t_reset();
    wrap_up();
  end
  // Normal run is near 36k cycles; reaching 90k means a hang
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    errors++;
    $display("Watchdog expired at t=%0t", $time);
    wrap_up();
  end
endmodule
